// File: hdl/lic_ctrl_regs.sv
// Purpose: line interface control register bank and the control it steers
// Assumes: synchronous control port, synchronous transmit bit stream
// Notes:   analog driver, equalizer and attenuator datapath live elsewhere

`timescale 1ns/1ps

// Summary of operation
// R1: gain override clear gives automatic gain; set uses six manual gain bits.
// R2: custom driver with zero build-out drives a square wave.
// R3: custom driver with nonzero build-out makes the drivers open drain.
// R4: in E1, current limit off bit disables the 50mA limiter.
// R5: composite-clock receive filter engages only in composite-clock mode.
// R6: low attenuator clock select enables the 2.048 to 1.544MHz PLL.
// R7: high attenuator clock select enables the 12.8 to 2.048MHz PLL.
// R8: software programs clock selects and prescaler even without attenuation.
// R9: in T1, E1, J1, alarm control zero sends unframed all ones.
// R10: in composite-clock modes, alarm control zero sends ones without violations.
// R11: a zero-to-one write of violation insert arms one violation.
// R12: the armed violation goes out at the next three consecutive ones.
// R13: software clears then sets violation insert for another violation.
// R14: zero-to-one write of line reset resets recovery and recenters attenuator.
// R15: alternating pattern bit sends continuous one-zero pattern.
// R16: monitor gain field selects boost, only in T1 or E1.
// R17: resistor select tells 120 or 133 ohm external; 120 cannot give 133.
// R18: CMI invert flips CMI on transmit and receive.
// R19: CMI enable switches the line into CMI coding.
// R20: receive termination field with resistor select picks the termination.
// R21: transmit termination field picks the internal source termination.
// R22: software writes zero to unused control and gain bits.
// R23: software selects build-out 000 or 001 with internal termination.
// R24: E1 with 12.8MHz master clock uses high select only, prescaler zero.
// R25: zero-to-one is found by comparing a write with the stored value.
module lic_ctrl_regs
  import lic_pkg::*;
(
  input  wire logic      sys_clk_in,          // system clock, 250 MHz
  input  wire logic      rst_in,              // async reset, high
  input  wire logic [7:0] addr_in,            // control port address
  input  wire logic      wr_en_in,            // write strobe
  input  wire logic [7:0] wr_data_in,         // write data
  input  wire logic      rd_en_in,            // read strobe
  output logic      [7:0] rd_data_out,        // read data, next cycle
  input  wire lic_mode_t line_mode_in,        // operating line mode
  input  wire logic [2:0] buildout_sel_in,    // build-out select from line_ctrl_one
  input  wire logic      tx_bit_valid_in,     // transmit bit strobe
  input  wire logic      tx_bit_in,           // transmit bit, one = mark
  output logic           manual_gain_out,     // manual gain in use
  output logic      [5:0] gain_level_out,     // manual gain level
  output lic_drv_t       driver_mode_out,     // transmit driver mode
  output logic           current_limit_en_out,// transmit limiter active
  output logic           cc_filter_en_out,    // composite clock filter on
  output logic           pll_to_1544_en_out,  // 2.048 to 1.544 PLL on
  output logic           pll_to_2048_en_out,  // 12.8 to 2.048 PLL on
  output logic      [1:0] prescale_out,       // master clock prescaler
  output lic_pat_t       tx_pattern_out,      // transmit pattern select
  output logic           bpv_insert_out,      // one-cycle violation insert
  output logic           bpv_armed_out,       // violation waiting
  output logic           line_reset_out,      // one-cycle line reset
  output logic      [1:0] monitor_boost_out,  // monitor gain boost code
  output logic           cmi_en_out,          // CMI coding on
  output logic           cmi_tx_inv_out,      // invert transmit CMI
  output logic           cmi_rx_inv_out,      // invert receive CMI
  output lic_term_t      rx_term_out,         // receive termination
  output lic_term_t      tx_term_out          // transmit termination
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] two_q;
  logic [7:0] three_q;
  logic [7:0] four_q;
  logic [7:0] gain_q;

  // address decode
  wire logic hit_two   = (addr_in == LIC_OFS_CTRL_TWO);
  wire logic hit_three = (addr_in == LIC_OFS_CTRL_THREE);
  wire logic hit_four  = (addr_in == LIC_OFS_CTRL_FOUR);
  wire logic hit_gain  = (addr_in == LIC_OFS_GAIN);
  wire logic wr_two    = wr_en_in & hit_two;

  // unused bits are not stored, so they always read back zero
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      two_q   <= LIC_RST_VAL;
      three_q <= LIC_RST_VAL;
      four_q  <= LIC_RST_VAL;
      gain_q  <= LIC_RST_VAL;
    end else if (wr_en_in) begin
      if (hit_two) two_q <= wr_data_in;
      if (hit_three) three_q <= wr_data_in & LIC_THREE_USED;  // R22
      if (hit_four) four_q <= wr_data_in;
      if (hit_gain) gain_q <= wr_data_in & LIC_GAIN_USED;  // R22
    end
  end

  // read mux; unmapped addresses answer zero
  wire logic [7:0] rd_d = hit_two   ? two_q   :
                          hit_three ? three_q :
                          hit_four  ? four_q  :
                          hit_gain  ? gain_q  : LIC_RD_UNMAPPED;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= LIC_RST_VAL;
    end else if (rd_en_in) begin
      rd_data_out <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // write-edge pulses
  // ---------------------------------------------------------------
  logic [1:0] rise_pulse;

  // bit 0 violation insert, bit 1 line reset
  lic_rise_det #(.W(2)) u_rise (  // R25
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .wr_in      (wr_two),
    .new_in     ({wr_data_in[LIC_B_LINE_RST], wr_data_in[LIC_B_VIOL_INS]}),
    .old_in     ({two_q[LIC_B_LINE_RST], two_q[LIC_B_VIOL_INS]}),
    .pulse_out  (rise_pulse)
  );

  // ---------------------------------------------------------------
  // decoded control
  // ---------------------------------------------------------------
  wire logic is_e1    = (line_mode_in == LIC_MODE_E1);
  wire logic is_cc    = (line_mode_in == LIC_MODE_CC);
  wire logic t1_or_e1 = (line_mode_in == LIC_MODE_T1) | is_e1;
  wire logic custom   = two_q[LIC_B_CUSTOM_DRV];

  wire logic [5:0] gain_d = gain_q[LIC_B_GAIN_OVR] ? gain_q[5:0] : LIC_GAIN_AUTO;  // R1

  wire lic_drv_t drv_d = !custom                  ? LIC_DRV_NORMAL :
                         (buildout_sel_in == 3'h0) ? LIC_DRV_SQUARE  // R2
                                                   : LIC_DRV_OPEN_DRAIN;  // R3

  // limiter only switchable in E1; other modes keep it running
  wire logic lim_d = !(is_e1 & two_q[LIC_B_CUR_LIM_OFF]);  // R4
  wire logic ccf_d = is_cc & two_q[LIC_B_CC_FILT];  // R5

  // alternating test pattern overrides the alarm pattern
  wire lic_pat_t pat_d = three_q[LIC_B_ALT_PAT]    ? LIC_PAT_ALTERNATE :  // R15
                         two_q[LIC_B_ALARM_CTRL]   ? LIC_PAT_DATA :
                         is_cc                     ? LIC_PAT_ONES_NO_BPV  // R10
                                                   : LIC_PAT_ALL_ONES;  // R9

  wire logic [1:0] mon_d = t1_or_e1 ? three_q[LIC_B_MON_HI:LIC_B_MON_LO] : 2'h0;  // R16

  // receive termination; 133 needs the 133 ohm resistor fitted
  wire logic [2:0] rx_code = four_q[LIC_B_RX_TERM_LO +: 3];
  wire logic       ext133  = three_q[LIC_B_EXT_RES];
  lic_term_t       rx_d;
  always_comb begin
    case (rx_code)  // R20
      LIC_TERM_75:  rx_d = LIC_TRM_75;
      LIC_TERM_100: rx_d = LIC_TRM_100;
      LIC_TERM_120: rx_d = LIC_TRM_120;
      LIC_TERM_110: rx_d = LIC_TRM_110;
      LIC_TERM_133: rx_d = ext133 ? LIC_TRM_133 : LIC_TRM_EXT;  // R17
      default:      rx_d = LIC_TRM_EXT;
    endcase
  end

  wire logic [2:0] tx_code = four_q[LIC_B_TX_TERM_LO +: 3];
  lic_term_t       tx_d;
  always_comb begin
    case (tx_code)  // R21
      LIC_TERM_75:  tx_d = LIC_TRM_75;
      LIC_TERM_100: tx_d = LIC_TRM_100;
      LIC_TERM_120: tx_d = LIC_TRM_120;
      LIC_TERM_110: tx_d = LIC_TRM_110;
      LIC_TERM_133: tx_d = LIC_TRM_133;
      default:      tx_d = LIC_TRM_OFF;
    endcase
  end

  // registered outputs, one cycle behind the stored settings
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      manual_gain_out      <= 1'b0;
      gain_level_out       <= LIC_GAIN_AUTO;
      driver_mode_out      <= LIC_DRV_NORMAL;
      current_limit_en_out <= 1'b1;
      cc_filter_en_out     <= 1'b0;
      pll_to_1544_en_out   <= 1'b0;
      pll_to_2048_en_out   <= 1'b0;
      prescale_out         <= 2'h0;
      tx_pattern_out       <= LIC_PAT_ALL_ONES;
      monitor_boost_out    <= 2'h0;
      cmi_en_out           <= 1'b0;
      cmi_tx_inv_out       <= 1'b0;
      cmi_rx_inv_out       <= 1'b0;
      rx_term_out          <= LIC_TRM_EXT;
      tx_term_out          <= LIC_TRM_OFF;
      line_reset_out       <= 1'b0;
    end else begin
      manual_gain_out      <= gain_q[LIC_B_GAIN_OVR];  // R1
      gain_level_out       <= gain_d;
      driver_mode_out      <= drv_d;
      current_limit_en_out <= lim_d;
      cc_filter_en_out     <= ccf_d;
      pll_to_1544_en_out   <= two_q[LIC_B_JA_SEL_LO];  // R6
      pll_to_2048_en_out   <= two_q[LIC_B_JA_SEL_HI];  // R7
      prescale_out         <= four_q[LIC_B_PRESC_LO +: 2];
      tx_pattern_out       <= pat_d;
      monitor_boost_out    <= mon_d;
      cmi_en_out           <= three_q[LIC_B_CMI_EN];  // R19
      cmi_tx_inv_out       <= three_q[LIC_B_CMI_INV];  // R18
      cmi_rx_inv_out       <= three_q[LIC_B_CMI_INV];  // R18
      rx_term_out          <= rx_d;
      tx_term_out          <= tx_d;
      line_reset_out       <= rise_pulse[1];  // R14
    end
  end

  // ---------------------------------------------------------------
  // single violation insertion
  // ---------------------------------------------------------------
  logic [1:0] ones_q;
  logic       armed_q;
  wire logic  one_bit  = tx_bit_valid_in & tx_bit_in;
  wire logic  zero_bit = tx_bit_valid_in & !tx_bit_in;
  // run length counting saturates; a longer run still counts as three
  wire logic [1:0] ones_d = zero_bit ? 2'h0 :
                            (one_bit && ones_q != LIC_ONES_RUN) ? ones_q + 2'h1 : ones_q;
  wire logic  fire     = armed_q & one_bit & (ones_d == LIC_ONES_RUN);  // R12
  // a new arm in the firing cycle wins, so no request is lost
  wire logic  armed_d  = rise_pulse[0] | (armed_q & !fire);  // R11

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ones_q         <= 2'h0;
      armed_q        <= 1'b0;
      bpv_insert_out <= 1'b0;
      bpv_armed_out  <= 1'b0;
    end else begin
      ones_q         <= ones_d;
      armed_q        <= armed_d;
      bpv_insert_out <= fire;
      bpv_armed_out  <= armed_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_GAIN_AUTO: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R1
    !manual_gain_out |-> gain_level_out == LIC_GAIN_AUTO) else $error("gain level not automatic");
  AST_SQUARE: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R2
    custom && buildout_sel_in == 3'h0 |=> driver_mode_out == LIC_DRV_SQUARE) else $error("square wave missing");
  AST_OPEN_DRAIN: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R3
    custom && buildout_sel_in != 3'h0 |=> driver_mode_out == LIC_DRV_OPEN_DRAIN) else $error("open drain missing");
  AST_LIMIT: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R4
    !is_e1 |=> current_limit_en_out) else $error("limiter off outside E1");
  AST_CC_FILT: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R5
    cc_filter_en_out |-> $past(line_mode_in) == LIC_MODE_CC) else $error("filter outside composite mode");
  AST_ALARM: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R9
    !two_q[LIC_B_ALARM_CTRL] && !three_q[LIC_B_ALT_PAT] && !is_cc |=> tx_pattern_out == LIC_PAT_ALL_ONES)
    else $error("all ones not sent");
  AST_ARM_ONE: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R11
    wr_two && wr_data_in[LIC_B_VIOL_INS] && !two_q[LIC_B_VIOL_INS] |=> ##1 bpv_armed_out)
    else $error("violation not armed");
  AST_ONE_SHOT: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R12
    bpv_insert_out |-> !bpv_armed_out || $past(rise_pulse[0])) else $error("violation repeated");
  AST_ON_RUN: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R12
    bpv_insert_out |-> $past(ones_d) == LIC_ONES_RUN && $past(one_bit)) else $error("violation off a run");
  AST_LINE_RST: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R14
    line_reset_out |=> !line_reset_out) else $error("line reset longer than a cycle");
  AST_MONITOR: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R16
    !t1_or_e1 |=> monitor_boost_out == 2'h0) else $error("boost outside T1 or E1");
  AST_RX_133: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R17
    !ext133 |=> rx_term_out != LIC_TRM_133) else $error("133 without resistor");

  // settings follow their stored bits one edge later; the line reset pulse comes two edges after its write
  AST_NORMAL: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R3
    !custom |=> driver_mode_out == LIC_DRV_NORMAL) else $error("driver not normal");
  AST_LIMIT_E1: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R4
    is_e1 && two_q[LIC_B_CUR_LIM_OFF] |=> !current_limit_en_out) else $error("limiter not off");
  AST_CC_FILT_ON: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R5
    is_cc && two_q[LIC_B_CC_FILT] |=> cc_filter_en_out) else $error("filter not on");
  AST_PLL_LO: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R6
    pll_to_1544_en_out == $past(two_q[LIC_B_JA_SEL_LO])) else $error("low pll select lost");
  AST_PLL_HI: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R7
    pll_to_2048_en_out == $past(two_q[LIC_B_JA_SEL_HI])) else $error("high pll select lost");
  AST_CC_ONES: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R10
    !two_q[LIC_B_ALARM_CTRL] && !three_q[LIC_B_ALT_PAT] && is_cc |=> tx_pattern_out == LIC_PAT_ONES_NO_BPV)
    else $error("composite ones missing");
  AST_ALT_PAT: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R15
    three_q[LIC_B_ALT_PAT] |=> tx_pattern_out == LIC_PAT_ALTERNATE) else $error("alternating missing");
  AST_RST_RISE: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R14
    wr_two && wr_data_in[LIC_B_LINE_RST] && !two_q[LIC_B_LINE_RST] |=> ##1 line_reset_out)
    else $error("line reset missing");
  AST_CMI_INV: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R18
    cmi_tx_inv_out == $past(three_q[LIC_B_CMI_INV]) && cmi_rx_inv_out == cmi_tx_inv_out)
    else $error("cmi invert lost");
  AST_CMI_EN: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R19
    cmi_en_out == $past(three_q[LIC_B_CMI_EN])) else $error("cmi enable lost");
  AST_RX_EXT: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R20
    (rx_code == 3'h0 || rx_code > LIC_TERM_133) |=> rx_term_out == LIC_TRM_EXT) else $error("rx not external");
  AST_TX_OFF: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R21
    (tx_code == 3'h0 || tx_code > LIC_TERM_133) |=> tx_term_out == LIC_TRM_OFF) else $error("tx not off");

endmodule

// File: hdl/lic_rise_det.sv
// Purpose: catch a zero-to-one write of a control bit as one pulse
// Assumes: wr_in marks a write that replaces the stored bits
// Notes:   compares the written value with the stored value

`timescale 1ns/1ps

module lic_rise_det #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,  // system clock
  input  wire logic         rst_in,      // async reset, high
  input  wire logic         wr_in,       // register write strobe
  input  wire logic [W-1:0] new_in,      // value being written
  input  wire logic [W-1:0] old_in,      // value held before the write
  output logic      [W-1:0] pulse_out    // one-cycle rise pulse
);

  // ---------------------------------------------------------------
  // edge compare
  // ---------------------------------------------------------------
  // a steady one written again gives nothing, so software must clear first
  wire logic [W-1:0] rise_d = {W{wr_in}} & new_in & ~old_in;  // R25

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_out <= '0;
    end else begin
      pulse_out <= rise_d;
    end
  end

endmodule

// File: pkg/lic_pkg.sv
// Purpose: shared constants and types for the line interface control registers
// Assumes: 8-bit documented control port, byte offsets as printed
// Notes:   all register resets are the all-zero default

package lic_pkg;

  // ---------------------------------------------------------------
  // register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] LIC_OFS_CTRL_TWO   = 8'h31;
  localparam logic [7:0] LIC_OFS_CTRL_THREE = 8'h32;
  localparam logic [7:0] LIC_OFS_CTRL_FOUR  = 8'h33;
  localparam logic [7:0] LIC_OFS_GAIN       = 8'h34;
  localparam logic [7:0] LIC_RST_VAL        = 8'h00;
  localparam logic [7:0] LIC_RD_UNMAPPED    = 8'h00;

  // line_ctrl_two fields
  localparam int LIC_B_CUSTOM_DRV  = 0;
  localparam int LIC_B_CUR_LIM_OFF = 1;
  localparam int LIC_B_CC_FILT     = 2;
  localparam int LIC_B_JA_SEL_LO   = 3;
  localparam int LIC_B_ALARM_CTRL  = 4;
  localparam int LIC_B_VIOL_INS    = 5;
  localparam int LIC_B_LINE_RST    = 6;
  localparam int LIC_B_JA_SEL_HI   = 7;

  // line_ctrl_three fields
  localparam int LIC_B_ALT_PAT     = 0;
  localparam int LIC_B_MON_LO      = 3;
  localparam int LIC_B_MON_HI      = 4;
  localparam int LIC_B_EXT_RES     = 5;
  localparam int LIC_B_CMI_INV     = 6;
  localparam int LIC_B_CMI_EN      = 7;
  localparam logic [7:0] LIC_THREE_USED = 8'hf9;  // bits 1 and 2 unused

  // line_ctrl_four fields
  localparam int LIC_B_RX_TERM_LO  = 0;
  localparam int LIC_B_TX_TERM_LO  = 3;
  localparam int LIC_B_PRESC_LO    = 6;

  // transmit gain register fields
  localparam int LIC_B_GAIN_OVR    = 6;
  localparam logic [7:0] LIC_GAIN_USED  = 8'h7f;  // bit 7 unused
  localparam logic [5:0] LIC_GAIN_AUTO  = 6'h00;  // level output while automatic

  // termination field codes
  localparam logic [2:0] LIC_TERM_75   = 3'h1;
  localparam logic [2:0] LIC_TERM_100  = 3'h2;
  localparam logic [2:0] LIC_TERM_120  = 3'h3;
  localparam logic [2:0] LIC_TERM_110  = 3'h4;
  localparam logic [2:0] LIC_TERM_133  = 3'h5;

  // consecutive ones needed before a violation goes out
  localparam logic [1:0] LIC_ONES_RUN  = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {LIC_MODE_T1, LIC_MODE_E1, LIC_MODE_J1, LIC_MODE_CC} lic_mode_t;
  typedef enum logic [1:0] {LIC_DRV_NORMAL, LIC_DRV_SQUARE, LIC_DRV_OPEN_DRAIN} lic_drv_t;
  typedef enum logic [1:0] {LIC_PAT_DATA, LIC_PAT_ALL_ONES, LIC_PAT_ONES_NO_BPV, LIC_PAT_ALTERNATE} lic_pat_t;
  typedef enum logic [2:0] {LIC_TRM_OFF, LIC_TRM_EXT, LIC_TRM_75, LIC_TRM_100, LIC_TRM_110, LIC_TRM_120,
                            LIC_TRM_133} lic_term_t;

endpackage

// File: tb/lic_line_src_model.sv
// Purpose: transmit bit source standing in for the framer feeding the line
// Assumes: bits are strobed on the falling clock edge, msb first
// Notes:   between frames the bit line toggles so a stale value never reads as data

`timescale 1ns/1ps

module lic_line_src_model (
  input  wire logic sys_clk_in,  // system clock
  output logic      valid_out,   // bit strobe
  output logic      bit_out      // transmit bit, one = mark
);
  // ---------------------------------------------------------------
  // frame sender
  // ---------------------------------------------------------------
  initial begin
    valid_out = 1'b0;
    bit_out = 1'b0;
  end

  // slow mode leaves a gap cycle after each strobe
  task automatic send(input logic [7:0] b, input logic slow);
    for (int i = 7; i >= 0; i--) begin
      @(negedge sys_clk_in);
      valid_out = 1'b1;
      bit_out = b[i];
      if (slow) begin
        @(negedge sys_clk_in);
        valid_out = 1'b0;
        bit_out = ~bit_out;
      end
    end
    @(negedge sys_clk_in);
    valid_out = 1'b0;
    bit_out = ~bit_out;
  endtask
endmodule

// File: tb/lic_tb.sv
// Purpose: self-checking bench for the line interface control registers
// Assumes: inputs change on the falling edge; settings settle within two edges
// Notes:   pulse outputs are counted per cycle so a stretched pulse shows up

`timescale 1ns/1ps

module testbench
  import lic_pkg::*;
;
  logic       sys_clk_in, rst_in, wr_en_in, rd_en_in, tx_bit_valid_in, tx_bit_in;
  logic [7:0] addr_in, wr_data_in, rd_data_out;
  logic [2:0] buildout_sel_in;
  lic_mode_t  line_mode_in;
  logic       manual_gain_out, current_limit_en_out, cc_filter_en_out, pll_to_1544_en_out;
  logic       pll_to_2048_en_out, bpv_insert_out, bpv_armed_out, line_reset_out;
  logic       cmi_en_out, cmi_tx_inv_out, cmi_rx_inv_out;
  logic [5:0] gain_level_out;
  logic [1:0] prescale_out, monitor_boost_out;
  lic_drv_t   driver_mode_out;
  lic_pat_t   tx_pattern_out;
  lic_term_t  rx_term_out, tx_term_out;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         n_bpv = 0;
  int         n_lrst = 0;
  lic_term_t  tx_tab[8] = '{LIC_TRM_OFF, LIC_TRM_75, LIC_TRM_100, LIC_TRM_120,
                            LIC_TRM_110, LIC_TRM_133, LIC_TRM_OFF, LIC_TRM_OFF};
  lic_term_t  rxe;

  // ---------------------------------------------------------------
  // clock, design, line source
  // ---------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  lic_ctrl_regs i_dut (.sys_clk_in, .rst_in, .addr_in, .wr_en_in, .wr_data_in, .rd_en_in, .rd_data_out,
    .line_mode_in, .buildout_sel_in, .tx_bit_valid_in, .tx_bit_in, .manual_gain_out, .gain_level_out,
    .driver_mode_out, .current_limit_en_out, .cc_filter_en_out, .pll_to_1544_en_out, .pll_to_2048_en_out,
    .prescale_out, .tx_pattern_out, .bpv_insert_out, .bpv_armed_out, .line_reset_out, .monitor_boost_out,
    .cmi_en_out, .cmi_tx_inv_out, .cmi_rx_inv_out, .rx_term_out, .tx_term_out);
  lic_line_src_model i_src (.sys_clk_in(sys_clk_in), .valid_out(tx_bit_valid_in), .bit_out(tx_bit_in));

  // high cycles of each pulse output; one pulse must add exactly one
  always @(posedge sys_clk_in) begin
    n_bpv <= n_bpv + int'(bpv_insert_out);
    n_lrst <= n_lrst + int'(line_reset_out);
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // returns once the settings outputs have had time to follow
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr_in = a;
    wr_data_in = d;
    wr_en_in = 1'b1;
    @(negedge sys_clk_in);
    wr_en_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_in);
    addr_in = a;
    rd_en_in = 1'b1;
    @(negedge sys_clk_in);
    rd_en_in = 1'b0;
    chk(rd_data_out, e);
  endtask

  task final_report;
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    for (int a = 'h31; a <= 'h34; a++) rd(8'(a), LIC_RST_VAL);
    chk(tx_pattern_out, LIC_PAT_ALL_ONES);
    chk({current_limit_en_out, cc_filter_en_out, manual_gain_out}, 8'h04);
    chk(rx_term_out, LIC_TRM_EXT);
    chk(tx_term_out, LIC_TRM_OFF);
  endtask

  // unused bits are written as ones on purpose to see they are not stored
  task t_regs;
    wr(8'h32, 8'hff);
    rd(8'h32, 8'hf9);
    wr(8'h34, 8'hff);
    rd(8'h34, 8'h7f);
    wr(8'h33, 8'ha5);
    rd(8'h33, 8'ha5);
    wr(8'h35, 8'hff);
    rd(8'h35, LIC_RD_UNMAPPED);
    rd(8'h30, LIC_RD_UNMAPPED);
  endtask

  task t_gain;
    wr(8'h34, 8'h2a);
    chk({manual_gain_out, gain_level_out}, {2'h0, LIC_GAIN_AUTO});
    wr(8'h34, 8'h6a);
    chk({manual_gain_out, gain_level_out}, 8'h6a);
  endtask

  task t_drive;
    for (int b = 0; b < 8; b++) begin
      buildout_sel_in = 3'(b);
      wr(8'h31, 8'h01);
      chk(driver_mode_out, (b == 0) ? LIC_DRV_SQUARE : LIC_DRV_OPEN_DRAIN);
    end
    wr(8'h31, 8'h00);
    chk(driver_mode_out, LIC_DRV_NORMAL);
    buildout_sel_in = 3'h0;
  endtask

  // every mode against alarm, alternating, limiter and filter bits
  task t_line;
    for (int m = 0; m < 4; m++) begin
      line_mode_in = lic_mode_t'(m);
      for (int k = 0; k < 4; k++) begin
        wr(8'h31, k[0] ? 8'h16 : 8'h06);
        wr(8'h32, 8'(k[1]));
        chk(tx_pattern_out, k[1] ? LIC_PAT_ALTERNATE : k[0] ? LIC_PAT_DATA :
            (m == 3) ? LIC_PAT_ONES_NO_BPV : LIC_PAT_ALL_ONES);
        chk({current_limit_en_out, cc_filter_en_out}, {6'h0, m != 1, m == 3});
      end
      for (int g = 0; g < 4; g++) begin
        wr(8'h32, 8'(g << 3));
        chk(monitor_boost_out, (m < 2) ? 8'(g) : 8'h00);
      end
    end
    line_mode_in = LIC_MODE_E1;
  endtask

  // 12.8 MHz master clock in E1, then 8.192 MHz in T1 with prescale
  task t_clk;
    wr(8'h31, 8'h80);
    wr(8'h33, 8'h00);
    chk({pll_to_1544_en_out, pll_to_2048_en_out, prescale_out}, 8'h04);
    line_mode_in = LIC_MODE_T1;
    wr(8'h31, 8'h08);
    wr(8'h33, 8'h80);
    chk({pll_to_1544_en_out, pll_to_2048_en_out, prescale_out}, 8'h0a);
  endtask

  task t_cmi;
    wr(8'h32, 8'hc0);
    chk({cmi_en_out, cmi_tx_inv_out, cmi_rx_inv_out}, 8'h07);
    wr(8'h32, 8'h80);
    chk({cmi_en_out, cmi_tx_inv_out, cmi_rx_inv_out}, 8'h04);
    wr(8'h32, 8'h00);
    chk(cmi_en_out, 8'h00);
  endtask

  task t_term;
    for (int x = 0; x < 2; x++) begin
      wr(8'h32, 8'(x << 5));
      for (int c = 0; c < 8; c++) begin
        wr(8'h33, 8'(c * 9));
        rxe = (c == 0 || c > 5) ? LIC_TRM_EXT : tx_tab[c];
        if (c == 5 && x == 0) rxe = LIC_TRM_EXT;
        chk(rx_term_out, rxe);
        chk(tx_term_out, tx_tab[c]);
      end
    end
  endtask

  // run broken by a zero, then three ones sent slowly
  task t_bpv;
    i_src.send(8'h00, 1'b0);
    wr(8'h31, 8'h20);
    chk(bpv_armed_out, 8'h01);
    i_src.send(8'h36, 1'b0);
    chk({bpv_armed_out, 7'(n_bpv)}, 8'h80);
    i_src.send(8'he0, 1'b1);
    chk({bpv_armed_out, 7'(n_bpv)}, 8'h01);
    wr(8'h31, 8'h20);
    i_src.send(8'hff, 1'b0);
    chk({bpv_armed_out, 7'(n_bpv)}, 8'h01);
    wr(8'h31, 8'h00);
    wr(8'h31, 8'h20);
    i_src.send(8'hff, 1'b0);
    chk(8'(n_bpv), 8'h02);
  endtask

  task t_lrst;
    wr(8'h31, 8'h40);
    chk(8'(n_lrst), 8'h01);
    wr(8'h31, 8'h40);
    chk(8'(n_lrst), 8'h01);
    wr(8'h31, 8'h00);
    wr(8'h31, 8'h40);
    chk(8'(n_lrst), 8'h02);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    addr_in = 8'h00;
    wr_data_in = 8'h00;
    buildout_sel_in = 3'h0;
    line_mode_in = LIC_MODE_T1;
    repeat (10) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_reset();
    t_regs();
    t_gain();
    t_drive();
    t_line();
    t_clk();
    t_cmi();
    t_term();
    t_bpv();
    t_lrst();
    final_report();
  end

  // the full sequence needs well under ten thousand cycles
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule
